// >>> rtl/cgcr_map.vh
`ifndef CGCR_MAP_VH
`define CGCR_MAP_VH
`define CGCR_ADDR_CLKREQ_CFG 8'h05
`define CGCR_ADDR_CLKREQ_EN 8'h06
`define CGCR_ADDR_REV_MAKER 8'h07
`define CGCR_ADDR_PART_25M 8'h08
`define CGCR_ADDR_TEST_LEVEL 8'h09
`define CGCR_ADDR_MUX_STOP 8'h0A
`define CGCR_ADDR_LOW_POWER 8'h0B
`define CGCR_RST_CLKREQ_CFG 2'h0
`define CGCR_RST_CLKREQ_EN 5'h00
`define CGCR_RST_25M_EN 2'h3
`define CGCR_RST_TEST_LEVEL 8'h25
`define CGCR_RST_HOST_MASK 2'h3
`define CGCR_RST_LOW_POWER 1'h1
`define CGCR_B5_D_EN 1
`define CGCR_B5_D_SEL 0
`define CGCR_B6_E_EN 7
`define CGCR_B6_H_EN 4
`define CGCR_B6_SRC_STP 0
`define CGCR_B9_PF5_STP 7
`define CGCR_B9_REF_BIT1 5
`define CGCR_B9_TEST_SEL 4
`define CGCR_B9_TEST_ENTRY 3
`define CGCR_B10_MUX_STAT 7
`define CGCR_B11_25M_LP 5
`endif

// >>> rtl/cgcr_gate.v
`timescale 1ns/1ps
// glitch-free run/stop for WIDTH output groups, one flop each: stop takes effect and releases
// only on a registered boundary, so no short pulse reaches the output gate
module cgcr_gate #(
    parameter WIDTH = 1
) (
    input wire core_clk,
    input wire srst,
    input wire [WIDTH-1:0] stop_req,
    output reg [WIDTH-1:0] run_q
);
    genvar g;
    generate
        for (g = 0; g < WIDTH; g = g + 1) begin : gen_gate
            always @(posedge core_clk) begin
                if (srst) begin
                    run_q[g] <= 1'b1;
                end else begin
                    run_q[g] <= ~stop_req[g];
                end
            end
        end
    endgenerate
endmodule

// >>> rtl/cgcr_regs.v
`timescale 1ns/1ps
`include "cgcr_map.vh"
// Overview of operation
// RULE_01: byte5 bit1 enables request D, bit0 maps pair
// RULE_02: byte6 bits7-4 enable requests E,F,G,H
// RULE_03: byte6 bit0 lets peripheral stop halt pairs
// RULE_04: byte8 bits1,0 enable both 25MHz outputs
// RULE_05: byte9 bit7 lets peripheral stop halt output five
// RULE_06: byte9 bit5 holds reference drive bit one
// RULE_07: byte9 bit4 picks tristate or divided reference
// RULE_08: byte9 bit3 enters selected test mode
// RULE_09: byte9 bits2-0 serial output level code
// RULE_10: byte10 bit7 reports latched mux pin status
// RULE_11: byte10 bits1,0 make host outputs stoppable
// RULE_12: byte11 bit5 keeps first 25MHz in low power, sticky
// RULE_13: deasserted enabled request stops mapped pair cleanly
// RULE_14: id fields and reserved bits ignore writes
module cgcr_regs #(
    // arbitrary identification values
    parameter [3:0] REV_CODE = 4'h5,
    parameter [3:0] MAKER_CODE = 4'h6,
    parameter [3:0] PART_CODE = 4'hA
) (
    input wire core_clk,
    input wire srst,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata,
    output reg reg_ack,
    input wire clock_request_d_input_n,
    input wire [3:0] clock_request_efgh_n,
    input wire periph_stop_n,
    input wire host_stop_n,
    input wire mux_pin_strap,
    input wire low_power_active,
    output wire [4:0] serial_pair_run,
    output wire [3:0] fixed_serial_run,
    output wire free_periph5_run,
    output wire [1:0] host_run,
    output reg first_25mhz_output_en,
    output reg second_25mhz_output_en,
    output wire ref_drive_bit1,
    output wire [2:0] serial_output_level_code,
    output reg test_tristate_all,
    output reg test_ref_div_all
);
    reg [1:0] clkreq_cfg_q;
    reg [4:0] clkreq_en_q;
    reg [1:0] en25m_q;
    reg [7:0] test_level_q;
    reg [1:0] host_mask_q;
    reg low_power_keep_q;
    reg mux_status_q;
    reg strap_taken_q;
    reg [7:0] rdata_d;
    reg [4:0] pair_stop;
    wire [3:0] fixed_stop;
    wire wr_ok;
    wire wr_clkreq_cfg;
    wire wr_clkreq_en;
    wire wr_part_25m;
    wire wr_test_level;
    wire wr_mux_stop;
    wire wr_low_power;
    wire periph_stop_on;
    wire host_stop_on;
    wire req_d_stop;
    wire pair_group_stop;
    wire pf5_stop;
    wire [1:0] host_stop;
    wire [11:0] stop_all;
    wire [11:0] run_all;
    wire [7:0] view_clkreq_cfg;
    wire [7:0] view_clkreq_en;
    wire [7:0] view_rev_maker;
    wire [7:0] view_part_25m;
    wire [7:0] view_mux_stop;
    wire [7:0] view_low_power;
    wire first_25m_en_d;
    wire second_25m_en_d;
    wire test_tristate_d;
    wire test_ref_div_d;

    function hit;
        input [7:0] addr;
        input [7:0] target;
        begin
            hit = (addr == target);
        end
    endfunction

    // one strobe per writable byte; byte 7 gets none, so the id cannot change
    assign wr_ok = reg_wr & ~srst;
    assign wr_clkreq_cfg = wr_ok & hit(reg_addr, `CGCR_ADDR_CLKREQ_CFG);
    assign wr_clkreq_en = wr_ok & hit(reg_addr, `CGCR_ADDR_CLKREQ_EN);
    assign wr_part_25m = wr_ok & hit(reg_addr, `CGCR_ADDR_PART_25M);
    assign wr_test_level = wr_ok & hit(reg_addr, `CGCR_ADDR_TEST_LEVEL);
    assign wr_mux_stop = wr_ok & hit(reg_addr, `CGCR_ADDR_MUX_STOP);
    assign wr_low_power = wr_ok & hit(reg_addr, `CGCR_ADDR_LOW_POWER);

    // RULE_01: request D cfg
    always @(posedge core_clk) begin
        if (srst) begin
            clkreq_cfg_q <= `CGCR_RST_CLKREQ_CFG;
        end else if (wr_clkreq_cfg) begin
            clkreq_cfg_q <= reg_wdata[`CGCR_B5_D_EN:`CGCR_B5_D_SEL];
        end
    end

    // RULE_02: request enables
    always @(posedge core_clk) begin
        if (srst) begin
            clkreq_en_q <= `CGCR_RST_CLKREQ_EN;
        end else if (wr_clkreq_en) begin
            clkreq_en_q <= {reg_wdata[`CGCR_B6_E_EN:`CGCR_B6_H_EN], reg_wdata[`CGCR_B6_SRC_STP]};
        end
    end

    // RULE_04: 25MHz enables
    always @(posedge core_clk) begin
        if (srst) begin
            en25m_q <= `CGCR_RST_25M_EN;
        end else if (wr_part_25m) begin
            en25m_q <= reg_wdata[1:0];
        end
    end

    // RULE_14: reserved bit6 dropped
    always @(posedge core_clk) begin
        if (srst) begin
            test_level_q <= `CGCR_RST_TEST_LEVEL;
        end else if (wr_test_level) begin
            test_level_q <= reg_wdata & 8'hBF;
        end
    end

    // RULE_11: host masks
    always @(posedge core_clk) begin
        if (srst) begin
            host_mask_q <= `CGCR_RST_HOST_MASK;
        end else if (wr_mux_stop) begin
            host_mask_q <= reg_wdata[1:0];
        end
    end

    // RULE_12: sticky once set
    always @(posedge core_clk) begin
        if (srst) begin
            low_power_keep_q <= `CGCR_RST_LOW_POWER;
        end else if (wr_low_power) begin
            low_power_keep_q <= low_power_keep_q | reg_wdata[`CGCR_B11_25M_LP];
        end
    end

    // RULE_10: strap caught once after reset release
    always @(posedge core_clk) begin
        if (srst) begin
            strap_taken_q <= 1'b0;
        end else begin
            strap_taken_q <= 1'b1;
        end
    end

    // RULE_10: status latched, later pin changes ignored
    always @(posedge core_clk) begin
        if (srst) begin
            mux_status_q <= 1'b0;
        end else if (!strap_taken_q) begin
            mux_status_q <= mux_pin_strap;
        end
    end

    // RULE_14: fixed id read back; reserved bits read 0
    assign view_clkreq_cfg = {6'h00, clkreq_cfg_q};
    assign view_clkreq_en = {clkreq_en_q[4:1], 3'h0, clkreq_en_q[0]};
    assign view_rev_maker = {REV_CODE, MAKER_CODE};
    assign view_part_25m = {PART_CODE, 2'h0, en25m_q};
    assign view_mux_stop = {mux_status_q, 5'h00, host_mask_q};
    assign view_low_power = {2'h0, low_power_keep_q, 5'h00};

    always @* begin
        rdata_d = 8'h00;
        case (reg_addr)
            `CGCR_ADDR_CLKREQ_CFG: rdata_d = view_clkreq_cfg;
            `CGCR_ADDR_CLKREQ_EN: rdata_d = view_clkreq_en;
            `CGCR_ADDR_REV_MAKER: rdata_d = view_rev_maker;
            `CGCR_ADDR_PART_25M: rdata_d = view_part_25m;
            `CGCR_ADDR_TEST_LEVEL: rdata_d = test_level_q;
            `CGCR_ADDR_MUX_STOP: rdata_d = view_mux_stop;
            `CGCR_ADDR_LOW_POWER: rdata_d = view_low_power;
            default: rdata_d = 8'h00;
        endcase
    end

    always @(posedge core_clk) begin
        if (srst) begin
            reg_ack <= 1'b0;
        end else begin
            reg_ack <= reg_wr | reg_rd;
        end
    end

    // read data holds until the next read
    always @(posedge core_clk) begin
        if (srst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= rdata_d;
        end
    end

    assign periph_stop_on = ~periph_stop_n;
    assign host_stop_on = ~host_stop_n;
    // RULE_13: request D deasserted
    assign req_d_stop = clkreq_cfg_q[1] & clock_request_d_input_n;
    // RULE_03: peripheral stop on pairs
    assign pair_group_stop = clkreq_en_q[0] & periph_stop_on;
    // RULE_05: output five stop
    assign pf5_stop = test_level_q[`CGCR_B9_PF5_STP] & periph_stop_on;
    // RULE_11: host stop
    assign host_stop = host_mask_q & {2{host_stop_on}};

    // stop per pair: 0 first, 1 fourth; 4..2 follow only the peripheral stop
    always @* begin
        pair_stop = {5{pair_group_stop}};
        // RULE_13: request D stops its pair
        if (req_d_stop) begin
            if (clkreq_cfg_q[0]) begin
                pair_stop[1] = 1'b1;
            end else begin
                pair_stop[0] = 1'b1;
            end
        end
    end

    // RULE_02: fixed targets six, eight, nine, ten; pair stop also halts them
    genvar t;
    generate
        for (t = 0; t < 4; t = t + 1) begin : gen_fixed_stop
            assign fixed_stop[t] = (clkreq_en_q[t + 1] & clock_request_efgh_n[t]) | pair_group_stop;
        end
    endgenerate

    // every output group passes one flop so a stop never cuts a pulse short
    assign stop_all = {pair_stop, fixed_stop, pf5_stop, host_stop};
    assign {serial_pair_run, fixed_serial_run, free_periph5_run, host_run} = run_all;

    cgcr_gate #(.WIDTH(12)) u_gate (
        .core_clk(core_clk),
        .srst(srst),
        .stop_req(stop_all),
        .run_q(run_all)
    );

    // RULE_06: drive bit
    assign ref_drive_bit1 = test_level_q[`CGCR_B9_REF_BIT1];
    // RULE_09: level code
    assign serial_output_level_code = test_level_q[2:0];

    // RULE_12: first 25MHz survives low power only when kept
    assign first_25m_en_d = en25m_q[1] & (~low_power_active | low_power_keep_q);
    // RULE_04: second 25MHz always drops in low power
    assign second_25m_en_d = en25m_q[0] & ~low_power_active;
    // RULE_08: entry gates both test modes
    assign test_tristate_d = test_level_q[`CGCR_B9_TEST_ENTRY] & ~test_level_q[`CGCR_B9_TEST_SEL];
    // RULE_07: mode select
    assign test_ref_div_d = test_level_q[`CGCR_B9_TEST_ENTRY] & test_level_q[`CGCR_B9_TEST_SEL];

    // RULE_04: first 25MHz enable
    always @(posedge core_clk) begin
        if (srst) begin
            first_25mhz_output_en <= 1'b1;
        end else begin
            first_25mhz_output_en <= first_25m_en_d;
        end
    end

    // RULE_04: second 25MHz enable
    always @(posedge core_clk) begin
        if (srst) begin
            second_25mhz_output_en <= 1'b1;
        end else begin
            second_25mhz_output_en <= second_25m_en_d;
        end
    end

    // RULE_07: tristate test mode
    always @(posedge core_clk) begin
        if (srst) begin
            test_tristate_all <= 1'b0;
        end else begin
            test_tristate_all <= test_tristate_d;
        end
    end

    // RULE_08: divided reference test mode
    always @(posedge core_clk) begin
        if (srst) begin
            test_ref_div_all <= 1'b0;
        end else begin
            test_ref_div_all <= test_ref_div_d;
        end
    end
endmodule

// >>> bench/cgcr_monitor.sv
`timescale 1ns/1ps
module cgcr_monitor #(
    // arbitrary id values
    parameter [3:0] REV_CODE = 4'h5,
    parameter [3:0] MAKER_CODE = 4'h6
) (
    input wire core_clk,
    input wire srst,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire [7:0] reg_rdata,
    input wire reg_ack,
    input wire periph_stop_n,
    input wire host_stop_n,
    input wire [4:0] serial_pair_run,
    input wire free_periph5_run,
    input wire [1:0] host_run,
    input wire [2:0] serial_output_level_code,
    input wire test_tristate_all,
    input wire test_ref_div_all
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (srst);
    wire wr9 = reg_wr && reg_addr == 8'h09;
    chk_ack_pulse: assert property ((reg_wr || reg_rd) |=> reg_ack)
        else $error("no ack");
    chk_id_fixed: assert property (reg_rd && reg_addr == 8'h07 |=> reg_rdata == {REV_CODE, MAKER_CODE})
        else $error("id");
    chk_level_code: assert property (wr9 |=> serial_output_level_code == 3'($past(reg_wdata)))
        else $error("level");
    chk_test_tristate: assert property (wr9 && reg_wdata[4:3] == 2'h1 |=> ##1 test_tristate_all)
        else $error("tristate");
    chk_test_refdiv: assert property (wr9 && reg_wdata[4:3] == 2'h3 |=> ##1 test_ref_div_all)
        else $error("ref div");
    chk_host_free: assert property (host_stop_n [*2] |-> host_run == 2'h3)
        else $error("host");
    chk_pf5_free: assert property (periph_stop_n |=> free_periph5_run)
        else $error("pf5");
    chk_pair_free: assert property (periph_stop_n |=> &serial_pair_run[4:2])
        else $error("pairs");
    cover property (wr9 && reg_wdata[4:3] == 2'h3);
    cover property (host_run != 2'h3);
    cover property (!serial_pair_run[0]);
endmodule
bind cgcr_regs cgcr_monitor #(.REV_CODE(REV_CODE), .MAKER_CODE(MAKER_CODE)) cgcr_monitor_i (
    .core_clk(core_clk), .srst(srst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack), .periph_stop_n(periph_stop_n),
    .host_stop_n(host_stop_n), .serial_pair_run(serial_pair_run), .free_periph5_run(free_periph5_run),
    .host_run(host_run), .serial_output_level_code(serial_output_level_code),
    .test_tristate_all(test_tristate_all), .test_ref_div_all(test_ref_div_all));

// >>> bench/cgcr_host_model.sv
`timescale 1ns/1ps
module cgcr_host_model (
    input wire core_clk,
    input wire reg_ack,
    input wire [7:0] reg_rdata,
    output logic reg_wr = 1'b0,
    output logic reg_rd = 1'b0,
    output logic [7:0] reg_addr = 8'h00,
    output logic [7:0] reg_wdata = 8'h00
);
    // one-cycle strobe, then ack and data taken once settled; data line left inverted
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [8:0] q);
        @(posedge core_clk);
        {reg_wr, reg_rd, reg_addr, reg_wdata} <= {w, !w, a, d};
        @(posedge core_clk);
        {reg_wr, reg_rd, reg_wdata} <= {2'h0, ~d};
        #1 q = {reg_ack, reg_rdata};
    endtask
endmodule

// >>> bench/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic core_clk = 0, srst = 1, clock_request_d_input_n = 1, periph_stop_n = 1, host_stop_n = 1;
    logic mux_pin_strap = 1, low_power_active = 0, reg_wr, reg_rd, reg_ack, first_25mhz_output_en;
    logic second_25mhz_output_en, free_periph5_run, ref_drive_bit1, test_tristate_all, test_ref_div_all, s;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, a, d, m [5:11];
    logic [7:0] wm [5:11] = '{8'h03, 8'hF1, 8'h00, 8'h03, 8'hBF, 8'h03, 8'h00};
    logic [15:0] cor [3] = '{16'h0B00, 16'h07FF, 16'h0918};
    logic [3:0] clock_request_efgh_n = 4'hF, fixed_serial_run;
    logic [4:0] serial_pair_run;
    logic [1:0] host_run;
    logic [2:0] serial_output_level_code;
    logic [8:0] q;
    int bad_count = 0, tests_run = 0;
    cgcr_regs cgcr_regs_i (
        .core_clk(core_clk), .srst(srst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
        .clock_request_d_input_n(clock_request_d_input_n), .clock_request_efgh_n(clock_request_efgh_n),
        .periph_stop_n(periph_stop_n), .host_stop_n(host_stop_n), .mux_pin_strap(mux_pin_strap),
        .low_power_active(low_power_active), .serial_pair_run(serial_pair_run),
        .fixed_serial_run(fixed_serial_run), .free_periph5_run(free_periph5_run), .host_run(host_run),
        .first_25mhz_output_en(first_25mhz_output_en), .second_25mhz_output_en(second_25mhz_output_en),
        .ref_drive_bit1(ref_drive_bit1), .serial_output_level_code(serial_output_level_code),
        .test_tristate_all(test_tristate_all), .test_ref_div_all(test_ref_div_all));
    cgcr_host_model host_i (.core_clk(core_clk), .reg_ack(reg_ack), .reg_rdata(reg_rdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
    function automatic logic [19:0] pins_exp();
        s = m[6][0] & !periph_stop_n;
        return {{3{!s}}, !(s | m[5][1] & m[5][0] & clock_request_d_input_n),
            !(s | m[5][1] & !m[5][0] & clock_request_d_input_n), ~({4{s}} | m[6][7:4] & clock_request_efgh_n),
            !(m[9][7] & !periph_stop_n), ~(m[10][1:0] & {2{!host_stop_n}}), m[8][1] & (!low_power_active | m[11][5]),
            m[8][0] & !low_power_active, m[9][3] & !m[9][4], m[9][3] & m[9][4], m[9][5], m[9][2:0]};
    endfunction
    task automatic chk(input logic [19:0] got, input logic [19:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic test_done();
        if (bad_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial forever #5 core_clk = ~core_clk;
    initial begin
        #100000;
        bad_count++;
        test_done();
    end
    // first nine passes read reset values of 0x04..0x0C, then corners, then random traffic
    initial begin
        m = '{8'h00, 8'h00, 8'h56, 8'hA3, 8'h25, 8'h83, 8'h20};
        void'($urandom(55236));
        repeat (4) @(posedge core_clk);
        srst <= 0;
        for (int i = 0; i < 90; i++) begin
            if (i == 45) begin
                // second reset with the strap low: latched status must then read 0
                @(posedge core_clk);
                {srst, mux_pin_strap} <= 2'b10;
                repeat (2) @(posedge core_clk);
                srst <= 0;
                m = '{8'h00, 8'h00, 8'h56, 8'hA3, 8'h25, 8'h03, 8'h20};
            end
            a = i < 9 ? 8'(i + 4) : i < 12 ? cor[i - 9][15:8] : 8'($urandom_range(13, 3));
            d = i < 12 ? cor[i % 3][7:0] : 8'($urandom);
            @(posedge core_clk);
            {clock_request_d_input_n, clock_request_efgh_n, periph_stop_n, host_stop_n, low_power_active} <= 8'($urandom);
            if (i >= 9) begin
                host_i.xfer(1'b1, a, d, q);
                chk(20'(q[8]), 20'h1);
                if (a inside {[5:11]}) m[a] = m[a] & ~wm[a] | d & wm[a];
            end
            host_i.xfer(1'b0, a, 8'h00, q);
            chk(20'(q), {12'h1, a inside {[5:11]} ? m[a] : 8'h00});
            chk({serial_pair_run, fixed_serial_run, free_periph5_run, host_run, first_25mhz_output_en,
                second_25mhz_output_en, test_tristate_all, test_ref_div_all, ref_drive_bit1,
                serial_output_level_code}, pins_exp());
        end
        test_done();
    end
endmodule
